// *** bench/dtcm_timer_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtcm_timer_sva
    import dtcm_pkg::*;
#(
    parameter int MC_DIV = MC_OSC_PERIODS
) (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus answers
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // status
    input wire logic        ovf_pulse_1
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_b_done: assert property (p_b_done) else $error("write answer not released");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
    a_r_done: assert property (p_r_done) else $error("read answer not released");
    property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while answer pending");
    property p_b_after; $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready); endproperty
    a_b_after: assert property (p_b_after) else $error("write answer without both handshakes");
    property p_r_after; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
    a_r_after: assert property (p_r_after) else $error("read answer without handshake");
    property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_r_upper: assert property (p_r_upper) else $error("read data upper bits set");
    property p_bresp; s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR; endproperty
    a_bresp: assert property (p_bresp) else $error("illegal write response");
    property p_pulse; ovf_pulse_1 && MC_DIV > 1 |=> !ovf_pulse_1; endproperty
    a_pulse: assert property (p_pulse) else $error("overflow pulse too long");
endmodule
bind dtcm_timer dtcm_timer_sva #(.MC_DIV(MC_DIV)) u_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ovf_pulse_1(ovf_pulse_1));
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
    import dtcm_pkg::*;
;
    logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0]     awaddr, araddr;
    logic [31:0]     wdata;
    logic            qual_0, cnt_0, ack_0, qual_1, cnt_1, ack_1;
    wire logic       awready, wready, bvalid, arready, rvalid, flag_0, flag_1, pulse_1, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int              mismatches, n_tests;
    logic [31:0]     d;
    logic [1:0]      r;
    logic            hit;
    // small divider keeps the run short
    dtcm_timer #(.ADDR_W(12), .MC_DIV(2)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_qualifier_pin_0(qual_0), .ext_qualifier_pin_1(qual_1),
        .count_input_pin_0(cnt_0), .count_input_pin_1(cnt_1), .int_ack_0(ack_0), .int_ack_1(ack_1),
        .overflow_flag_0(flag_0), .overflow_flag_1(flag_1), .ovf_pulse_1(pulse_1), .irq(irq));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // waits for the answer; only the watchdog ends a hang
    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] idx);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [9:0] idx, input logic [7:0] exp);
        rd(idx);
        chk(d, {24'h0, exp});
        chk(r, RESP_OKAY);
    endtask
    // bounded wait for flag 0, flag 1 or the unit 1 pulse
    task automatic wt(input int sel);
        int n;
        hit = 1'b0;
        for (n = 0; n < 2000 && hit !== 1'b1; n++) begin
            @(posedge aclk);
            #1;
            hit = (sel == 0) ? flag_0 : (sel == 1) ? flag_1 : pulse_1;
        end
    endtask
    task automatic t_reset();
        rc(IDX_CTRL_FLAGS, RST_BYTE);
        rc(IDX_LOW_0, RST_BYTE);
        rc(IDX_HIGH_1, RST_BYTE);
        rc(IDX_IRQ_MASK, {6'h0, RST_MASK});
        rd(10'h3ff);
        chk(r, RESP_SLVERR);
        wr(10'h3ff, 8'h5a);
        chk(r, RESP_SLVERR);
        wr(IDX_MODE_SEL, 8'h88);
        rc(IDX_MODE_SEL, 8'h88);
    endtask
    task automatic t_gate();
        wr(IDX_MODE_SEL, 8'h08);
        wr(IDX_LOW_0, 8'hff);
        wr(IDX_HIGH_0, 8'hff);
        wr(IDX_CTRL_FLAGS, 8'h10);
        repeat (40) @(posedge aclk);
        rc(IDX_LOW_0, 8'hff);
        rc(IDX_HIGH_0, 8'hff);
        qual_0 <= 1'b1;
        wt(0);
        wr(IDX_CTRL_FLAGS, 8'h20);
        chk(hit, 1'b1);
        rd(IDX_LOW_0);
        chk(d[4:3], 2'h0);
        rc(IDX_HIGH_0, 8'h00);
    endtask
    task automatic t_reload();
        rd(IDX_IRQ_STAT);
        wr(IDX_CTRL_FLAGS, 8'h00);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_MODE_SEL, 8'h02);
        wr(IDX_HIGH_0, 8'hf0);
        wr(IDX_LOW_0, 8'hfe);
        wr(IDX_CTRL_FLAGS, 8'h10);
        wt(0);
        wr(IDX_CTRL_FLAGS, 8'h20);
        chk(irq, 1'b1);
        rc(IDX_HIGH_0, 8'hf0);
        rd(IDX_LOW_0);
        chk(d[7:4], 4'hf);
        rc(IDX_IRQ_STAT, 8'h01);
        chk(irq, 1'b0);
        ack_0 <= 1'b1;
        @(posedge aclk);
        ack_0 <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(flag_0, 1'b0);
    endtask
    task automatic t_count();
        wr(IDX_MODE_SEL, 8'h05);
        wr(IDX_LOW_0, 8'h00);
        wr(IDX_HIGH_0, 8'h00);
        wr(IDX_CTRL_FLAGS, 8'h10);
        repeat (3) begin
            repeat (12) @(posedge aclk);
            cnt_0 <= 1'b0;
            repeat (12) @(posedge aclk);
            cnt_0 <= 1'b1;
        end
        repeat (12) @(posedge aclk);
        wr(IDX_CTRL_FLAGS, 8'h00);
        rc(IDX_LOW_0, 8'h03);
        rc(IDX_HIGH_0, 8'h00);
    endtask
    task automatic t_split();
        wr(IDX_MODE_SEL, 8'h33);
        wr(IDX_LOW_1, 8'h77);
        wr(IDX_HIGH_0, 8'hff);
        wr(IDX_CTRL_FLAGS, 8'h40);
        wt(1);
        chk(hit, 1'b1);
        rc(IDX_LOW_1, 8'h77);
        ack_1 <= 1'b1;
        @(posedge aclk);
        ack_1 <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(flag_1, 1'b0);
        // unit 1 reload mode, qualified by its own pin while unit 0 stays split
        wr(IDX_MODE_SEL, 8'ha3);
        wr(IDX_LOW_1, 8'hff);
        repeat (20) @(posedge aclk);
        rc(IDX_LOW_1, 8'hff);
        qual_1 <= 1'b1;
        wt(2);
        chk(hit, 1'b1);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, qual_0, ack_0, qual_1, ack_1} <= 10'h000;
        {awaddr, araddr, wdata} <= 56'h0;
        {cnt_0, cnt_1} <= 2'h3;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_gate();
        t_reload();
        t_count();
        t_split();
        end_sim();
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire

// *** rtl/dtcm_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module dtcm_timer
    import dtcm_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int MC_DIV = MC_OSC_PERIODS
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pins
    input  wire logic              ext_qualifier_pin_0,
    input  wire logic              ext_qualifier_pin_1,
    input  wire logic              count_input_pin_0,
    input  wire logic              count_input_pin_1,
    // interrupt vectoring acknowledges
    input  wire logic              int_ack_0,
    input  wire logic              int_ack_1,
    // status out
    output logic                   overflow_flag_0,
    output logic                   overflow_flag_1,
    output logic                   ovf_pulse_1,
    output logic                   irq
);
    // next {overflow, high, low} for one increment in modes 00..10
    function automatic logic [16:0] dtcm_step(input logic [1:0] m, input logic [7:0] h, input logic [7:0] l);
        logic [16:0] r;
        r = {1'b0, h, l};
        case (m)
            MODE_13BIT: begin
                // upper three low bits left alone; their content is undefined to software
                r[4:0] = l[4:0] + 5'h01;
                if (l[4:0] == 5'h1f) begin
                    r[15:8] = h + 8'h01;
                    r[16]   = (h == 8'hff);
                end
            end
            MODE_16BIT: begin
                r[15:0] = {h, l} + 16'h0001;
                r[16]   = ({h, l} == 16'hffff);
            end
            MODE_RELOAD: begin
                // high byte is only read here, never written
                r[7:0] = (l == 8'hff) ? h : l + 8'h01;
                r[16]  = (l == 8'hff);
            end
            default: r = {1'b0, h, l};
        endcase
        return r;
    endfunction

    // ---------------- machine cycle divider
    localparam int DIV_W = $clog2(MC_DIV + 1);
    logic [DIV_W-1:0] div_r;
    logic             mc_tick_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r     <= '0;
            mc_tick_r <= 1'b0;
        end else begin
            mc_tick_r <= (div_r == DIV_W'(MC_DIV - 1));
            div_r     <= (div_r == DIV_W'(MC_DIV - 1)) ? '0 : div_r + DIV_W'(1);
        end
    end

    // ---------------- pin synchronisers: {cin1, cin0, qual1, qual0}
    wire  [3:0] pins_in = {count_input_pin_1, count_input_pin_0, ext_qualifier_pin_1, ext_qualifier_pin_0};
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] pin_r;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                    sync3_r[g] <= 1'b0;
                    pin_r[g]   <= 1'b0;
                end else begin
                    sync1_r[g] <= pins_in[g];
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                    // a change counts only once the later stages agree
                    if (sync2_r[g] == sync3_r[g])
                        pin_r[g] <= sync3_r[g];
                end
            end
        end
    endgenerate

    // falling edge seen across two machine cycle samples
    logic [1:0] samp_r;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            samp_r <= 2'h0;
        else if (mc_tick_r)
            samp_r <= pin_r[3:2];
    end
    wire [1:0] pin_fall = samp_r & ~pin_r[3:2];

    // ---------------- registers
    logic [7:0] mode_r;
    logic [7:0] low0_r;
    logic [7:0] high0_r;
    logic [7:0] low1_r;
    logic [7:0] high1_r;
    logic       run0_r;
    logic       run1_r;
    logic       ovf0_r;
    logic       ovf1_r;
    logic [1:0] stat_r;
    logic [1:0] mask_r;

    // ---------------- bus slave
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    wire aw_take   = s_axi_awvalid & s_axi_awready;
    wire w_take    = s_axi_wvalid & s_axi_wready;
    wire wr_go     = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire ar_take   = s_axi_arvalid & s_axi_arready;
    wire [9:0] widx = awaddr_r[11:2];
    wire [9:0] ridx = s_axi_araddr[11:2];
    wire wr_en     = wr_go & wstrb_r[0];
    wire [7:0] wd  = wdata_r[7:0];
    wire wr_flags  = wr_en & (widx == IDX_CTRL_FLAGS);
    wire wr_mode   = wr_en & (widx == IDX_MODE_SEL);
    wire wr_low0   = wr_en & (widx == IDX_LOW_0);
    wire wr_low1   = wr_en & (widx == IDX_LOW_1);
    wire wr_high0  = wr_en & (widx == IDX_HIGH_0);
    wire wr_high1  = wr_en & (widx == IDX_HIGH_1);
    wire wr_mask   = wr_en & (widx == IDX_IRQ_MASK);
    wire w_mapped  = (widx >= IDX_CTRL_FLAGS && widx <= IDX_HIGH_1) || widx == IDX_IRQ_STAT || widx == IDX_IRQ_MASK;
    wire r_mapped  = (ridx >= IDX_CTRL_FLAGS && ridx <= IDX_HIGH_1) || ridx == IDX_IRQ_STAT || ridx == IDX_IRQ_MASK;
    wire rd_stat   = ar_take & (ridx == IDX_IRQ_STAT);
    wire [7:0] flags_view = {ovf1_r, run1_r, ovf0_r, run0_r, 4'h0};
    wire [7:0] rd_byte =
        (ridx == IDX_CTRL_FLAGS) ? flags_view :
        (ridx == IDX_MODE_SEL)   ? mode_r :
        (ridx == IDX_LOW_0)      ? low0_r :
        (ridx == IDX_LOW_1)      ? low1_r :
        (ridx == IDX_HIGH_0)     ? high0_r :
        (ridx == IDX_HIGH_1)     ? high1_r :
        (ridx == IDX_IRQ_STAT)   ? {6'h00, stat_r} :
        (ridx == IDX_IRQ_MASK)   ? {6'h00, mask_r} : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_r      <= '0;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= r_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ---------------- counting enables
    wire [1:0] mode0 = mode_r[MODE_LSB_0 +: 2];
    wire [1:0] mode1 = mode_r[MODE_LSB_0 + UNIT1_SHIFT +: 2];
    wire src0  = mode_r[SRC_BIT_0];
    wire src1  = mode_r[SRC_BIT_0 + UNIT1_SHIFT];
    wire qual0 = mode_r[QUAL_BIT_0];
    wire qual1 = mode_r[QUAL_BIT_0 + UNIT1_SHIFT];
    wire split0 = (mode0 == MODE_SPLIT);
    // in split mode unit 1 gives its run bit away and runs unless in its own split mode
    wire run1_eff = split0 ? 1'b1 : run1_r;
    wire en0 = run0_r & (~qual0 | pin_r[0]);
    wire en1 = run1_eff & (~qual1 | pin_r[1]);
    wire ev0 = mc_tick_r & (src0 ? pin_fall[0] : 1'b1);
    wire ev1 = mc_tick_r & (src1 ? pin_fall[1] : 1'b1);
    wire inc0 = en0 & ev0;
    wire inc1 = en1 & ev1 & (mode1 != MODE_SPLIT);
    wire inc_hi_split = split0 & run1_r & mc_tick_r;

    wire [16:0] nxt0 = dtcm_step(mode0, high0_r, low0_r);
    wire [16:0] nxt1 = dtcm_step(mode1, high1_r, low1_r);
    wire [7:0]  low0_split  = low0_r + 8'h01;
    wire [7:0]  high0_split = high0_r + 8'h01;
    wire ovf_low_split  = split0 & inc0 & (low0_r == 8'hff);
    wire ovf_high_split = inc_hi_split & (high0_r == 8'hff);
    wire ovf_unit0 = split0 ? ovf_low_split : (inc0 & nxt0[16]);
    wire ovf_unit1 = inc1 & nxt1[16];
    // flag 1 belongs to unit 0's high byte while unit 0 is split
    wire set_ovf0 = ovf_unit0;
    wire set_ovf1 = split0 ? ovf_high_split : ovf_unit1;

    // ---------------- count bytes, software write wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low0_r  <= RST_BYTE;
            high0_r <= RST_BYTE;
        end else begin
            if (wr_low0)
                low0_r <= wd;
            else if (split0 && inc0)
                low0_r <= low0_split;
            else if (!split0 && inc0)
                low0_r <= nxt0[7:0];
            if (wr_high0)
                high0_r <= wd;
            else if (inc_hi_split)
                high0_r <= high0_split;
            else if (!split0 && inc0)
                high0_r <= nxt0[15:8];
        end
    end

    // unit 1 never splits its bytes; split mode only borrows its run bit and flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low1_r  <= RST_BYTE;
            high1_r <= RST_BYTE;
        end else begin
            if (wr_low1)
                low1_r <= wd;
            else if (inc1)
                low1_r <= nxt1[7:0];
            if (wr_high1)
                high1_r <= wd;
            else if (inc1)
                high1_r <= nxt1[15:8];
        end
    end

    // ---------------- control, flags, interrupts
    // run bits only gate counting; they never reach the count bytes
    wire run0_nxt = wr_flags ? wd[BIT_RUN_0] : run0_r;
    wire run1_nxt = wr_flags ? wd[BIT_RUN_1] : run1_r;
    wire ovf0_kept = wr_flags ? wd[BIT_OVF_0] : (ovf0_r & ~int_ack_0);
    wire ovf1_kept = wr_flags ? wd[BIT_OVF_1] : (ovf1_r & ~int_ack_1);
    wire ovf0_nxt = set_ovf0 | ovf0_kept;
    wire ovf1_nxt = set_ovf1 | ovf1_kept;
    wire [1:0] stat_nxt = {set_ovf1, set_ovf0} | (stat_r & {2{~rd_stat}});
    wire [1:0] mask_nxt = wr_mask ? wd[1:0] : mask_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= RST_BYTE;
            mask_r <= RST_MASK;
        end else begin
            if (wr_mode)
                mode_r <= wd;
            mask_r <= mask_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run0_r <= 1'b0;
            run1_r <= 1'b0;
            ovf0_r <= 1'b0;
            ovf1_r <= 1'b0;
        end else begin
            run0_r <= run0_nxt;
            run1_r <= run1_nxt;
            ovf0_r <= ovf0_nxt;
            ovf1_r <= ovf1_nxt;
        end
    end

    // ports follow next state so each one leaves a flop without a cycle of lag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r          <= 2'h0;
            overflow_flag_0 <= 1'b0;
            overflow_flag_1 <= 1'b0;
            ovf_pulse_1     <= 1'b0;
            irq             <= 1'b0;
        end else begin
            stat_r          <= stat_nxt;
            overflow_flag_0 <= ovf0_nxt;
            overflow_flag_1 <= ovf1_nxt;
            // baud source keeps working while unit 0 owns flag 1
            ovf_pulse_1     <= ovf_unit1;
            irq             <= |(stat_nxt & mask_nxt);
        end
    end
endmodule
`default_nettype wire

// *** shared/dtcm_pkg.sv ***
// Overview of operation
// - qualify bit set: unit counts only while its qualifier pin is high and run set
// - source bit set counts falling edges on count pin, clear counts machine cycles
// - mode 00: 13-bit count, high byte above low byte's five prescaler bits
// - mode 01: high and low bytes cascade into a 16-bit counter, flag on rollover
// - mode 10: low byte counts, overflow sets flag and reloads it from high byte
// - auto-reload never changes the high-byte reload value
// - 13-bit rollover from all ones to zero sets the unit's overflow flag
// - setting run control does not touch the count bytes
// - mode register has qualify bit 7 for unit 1 and bit 3 for unit 0
// - unit 1 in split mode holds its count as if run were clear
// - split mode: unit 0 low byte is an 8-bit counter with unit 0 controls
// - split mode: unit 0 high byte times cycles, uses unit 1 run and flag
// - unit 1 keeps running outside its own split mode, overflow still usable
// - timer function increments once per machine cycle of six oscillator periods
// - counter samples pin each machine cycle, counts a high then low sample
// - overflow flag set by hardware, cleared when the interrupt is vectored
package dtcm_pkg;
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_CTRL_FLAGS = 10'h088;
    localparam logic [9:0] IDX_MODE_SEL   = 10'h089;
    localparam logic [9:0] IDX_LOW_0      = 10'h08a;
    localparam logic [9:0] IDX_LOW_1      = 10'h08b;
    localparam logic [9:0] IDX_HIGH_0     = 10'h08c;
    localparam logic [9:0] IDX_HIGH_1     = 10'h08d;
    localparam logic [9:0] IDX_IRQ_STAT   = 10'h090;
    localparam logic [9:0] IDX_IRQ_MASK   = 10'h091;
    // control flags fields
    localparam int BIT_OVF_1 = 7;
    localparam int BIT_RUN_1 = 6;
    localparam int BIT_OVF_0 = 5;
    localparam int BIT_RUN_0 = 4;
    // mode select fields, unit 1 sits four bits above unit 0
    localparam int MODE_LSB_0  = 0;
    localparam int SRC_BIT_0   = 2;
    localparam int QUAL_BIT_0  = 3;
    localparam int UNIT1_SHIFT = 4;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_MASK = 2'h0;
    // machine cycle length in oscillator periods (aclk)
    localparam int MC_OSC_PERIODS = 6;
    // modes
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
